// File: rtl/gpcd_pkg.sv
// Constants shared by the port C / port D block
`default_nettype none
package gpcd_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PORT_W = 8;

    // Register indices as printed; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_PORT_C_DATA = 12'h007;
    localparam logic [ADDR_W-1:0] IDX_PORT_D_DATA = 12'h008;
    localparam logic [ADDR_W-1:0] IDX_PORT_C_DIR = 12'h087;
    localparam logic [ADDR_W-1:0] IDX_PORT_D_DIR = 12'h088;
    localparam logic [ADDR_W-1:0] IDX_PORT_E_DIR = 12'h089;
    localparam logic [ADDR_W-1:0] ADDR_PORT_C_DATA = IDX_PORT_C_DATA << 2;
    localparam logic [ADDR_W-1:0] ADDR_PORT_D_DATA = IDX_PORT_D_DATA << 2;
    localparam logic [ADDR_W-1:0] ADDR_PORT_C_DIR = IDX_PORT_C_DIR << 2;
    localparam logic [ADDR_W-1:0] ADDR_PORT_D_DIR = IDX_PORT_D_DIR << 2;
    localparam logic [ADDR_W-1:0] ADDR_PORT_E_DIR = IDX_PORT_E_DIR << 2;

    // Reset values
    localparam logic [PORT_W-1:0] PORT_DIR_RST = 8'hff;
    localparam logic [PORT_W-1:0] PORT_LATCH_RST = 8'h00;
    localparam logic [2:0] PORT_E_DIR_RST = 3'h7;
    localparam logic PSP_MODE_RST = 1'b0;

    // Port E direction / slave status field positions
    localparam int unsigned PE_DIR_LSB = 0;
    localparam int unsigned PE_DIR_MSB = 2;
    localparam int unsigned PE_UNUSED_BIT = 3;
    localparam int unsigned PE_MODE_BIT = 4;
    localparam int unsigned PE_OVF_BIT = 5;
    localparam int unsigned PE_OUT_FULL_BIT = 6;
    localparam int unsigned PE_IN_FULL_BIT = 7;

    // Port C pin roles
    localparam int unsigned PC_T1_CLK_PIN = 0;
    localparam int unsigned PC_T1_OSC_PIN = 1;
    localparam int unsigned PC_CAPTURE_COMPARE_PWM_UNIT_ONE_PIN = 2;
    localparam int unsigned PC_SCLK_PIN = 3;
    localparam int unsigned PC_SDI_PIN = 4;
    localparam int unsigned PC_SDO_PIN = 5;
    localparam int unsigned PC_TX_PIN = 6;
    localparam int unsigned PC_RX_PIN = 7;

    // Pins that exist as peripheral pins on every variant; the USART pair 6 and 7 only with a USART
    localparam logic [PORT_W-1:0] PC_BASE_SEL_MASK = 8'h3f;
    localparam logic [PORT_W-1:0] PC_USART_SEL_MASK = 8'hc0;

    localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;
    localparam logic [PORT_W-1:0] BYTE_ZERO = 8'h00;
endpackage
`default_nettype wire

// File: rtl/gpcd_pin_sync.sv
// Two-flop synchroniser for a group of pin inputs
`default_nettype none
module gpcd_pin_sync #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule
`default_nettype wire

// File: rtl/gpcd_ports.sv
// Port C and port D pin logic with peripheral override and APB registers
//
// Operation
// - Per port C pin, select picks latch or peripheral as output value.
// - Peripheral output enable reaches a port C pin only while selected.
// - Port C direction bits reset to all ones on every reset.
// - Port D direction bits reset to all ones on every reset.
// - Each port D pin has its own direction bit.
// - Mode bit 4 of port E register turns port D into slave data port.
// - In slave mode port D pin n carries slave data bit n.
// - Port C pins 3, 4, 5 selectable as serial clock, data in, data out.
// - Port C pin 2 selectable for capture/compare/PWM unit one.
// - With USART, port C pins 6 and 7 serve transmit and receive.
// - With second CCP, port C pin 1 is oscillator and unit two pin.
// - Port C pin 0 selectable as timer1 oscillator or external clock.
// - Direction one means input, zero means output; clear latch first.
// - Unimplemented register bits read back as zero.
// - Enabled peripheral overrides direction bit for as long as enabled.
// - Data register read returns pin levels; write updates latch only.
`default_nettype none
module gpcd_ports
    import gpcd_pkg::*;
#(
    parameter bit HAS_USART = 1'b1,
    parameter bit HAS_CAPTURE_COMPARE_PWM_UNIT_TWO = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic other_reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpcd_pkg::ADDR_W-1:0] paddr,
    input wire logic [gpcd_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [gpcd_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [gpcd_pkg::PORT_W-1:0] port_c_pin_in,
    output logic [gpcd_pkg::PORT_W-1:0] port_c_pin_out,
    output logic [gpcd_pkg::PORT_W-1:0] port_c_pin_oe,
    input wire logic [gpcd_pkg::PORT_W-1:0] port_d_pin_in,
    output logic [gpcd_pkg::PORT_W-1:0] port_d_pin_out,
    output logic [gpcd_pkg::PORT_W-1:0] port_d_pin_oe,
    input wire logic [gpcd_pkg::PORT_W-1:0] periph_sel,
    input wire logic [gpcd_pkg::PORT_W-1:0] periph_out,
    input wire logic [gpcd_pkg::PORT_W-1:0] periph_oe,
    output logic [gpcd_pkg::PORT_W-1:0] port_c_level,
    output logic [gpcd_pkg::PORT_W-1:0] port_d_level,
    input wire logic [gpcd_pkg::PORT_W-1:0] slave_data_out,
    input wire logic slave_data_drive,
    input wire logic slave_input_full,
    input wire logic slave_output_full,
    input wire logic slave_input_overflow,
    output logic slave_overflow_clear,
    output logic parallel_slave_mode_select,
    output logic [2:0] port_e_direction
);
    import gpcd_pkg::*;

    // Register state
    logic [PORT_W-1:0] port_c_data_reg;
    logic [PORT_W-1:0] port_d_data_reg;
    logic [PORT_W-1:0] port_c_direction_reg;
    logic [PORT_W-1:0] port_d_direction_reg;
    logic [2:0] port_e_dir_reg;
    logic psp_mode_reg;
    logic ovf_clear_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic pslverr_reg;

    // Pin drivers, registered
    logic [PORT_W-1:0] pc_out_reg;
    logic [PORT_W-1:0] pc_oe_reg;
    logic [PORT_W-1:0] pd_out_reg;
    logic [PORT_W-1:0] pd_oe_reg;

    // Synchronised pin levels
    logic [PORT_W-1:0] pc_sync;
    logic [PORT_W-1:0] pd_sync;

    gpcd_pin_sync #(
        .WIDTH(PORT_W)
    ) u_sync_c (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(port_c_pin_in),
        .sync_out(pc_sync)
    );

    gpcd_pin_sync #(
        .WIDTH(PORT_W)
    ) u_sync_d (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(port_d_pin_in),
        .sync_out(pd_sync)
    );

    // APB phase decode
    wire setup_phase = psel & ~penable;
    wire access_phase = psel & penable;
    wire lane0_wr = pwrite & pstrb[0];
    wire wr_en = access_phase & lane0_wr;

    wire hit_pc_data = (paddr == ADDR_PORT_C_DATA);
    wire hit_pd_data = (paddr == ADDR_PORT_D_DATA);
    wire hit_pc_dir = (paddr == ADDR_PORT_C_DIR);
    wire hit_pd_dir = (paddr == ADDR_PORT_D_DIR);
    wire hit_pe_dir = (paddr == ADDR_PORT_E_DIR);
    wire hit_any = hit_pc_data | hit_pd_data | hit_pc_dir | hit_pd_dir | hit_pe_dir;

    // Unmapped writes are dropped, not stored
    wire wr_pc_data = wr_en & hit_pc_data;
    wire wr_pd_data = wr_en & hit_pd_data;
    wire wr_pc_dir = wr_en & hit_pc_dir;
    wire wr_pd_dir = wr_en & hit_pd_dir;
    wire wr_pe_dir = wr_en & hit_pe_dir;

    wire [PORT_W-1:0] pe_read = {
        slave_input_full,
        slave_output_full,
        slave_input_overflow,
        psp_mode_reg,
        1'b0,
        port_e_dir_reg
    };

    wire [PORT_W-1:0] read_byte =
        hit_pc_data ? pc_sync :
        hit_pd_data ? pd_sync :
        hit_pc_dir ? port_c_direction_reg :
        hit_pd_dir ? port_d_direction_reg :
        hit_pe_dir ? pe_read : BYTE_ZERO;

    wire [DATA_W-1:0] read_word = {{(DATA_W - PORT_W){1'b0}}, read_byte};

    wire [PORT_W-1:0] wbyte = pwdata[PORT_W-1:0];

    // Overflow flag is owned by slave logic; writing zero asks it to clear
    wire ovf_clear_next = wr_pe_dir & ~wbyte[PE_OVF_BIT];

    // Read data is captured in the setup cycle, answer comes with no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= RDATA_ZERO;
        end else if (setup_phase) begin
            prdata_reg <= pwrite ? RDATA_ZERO : read_word;
        end
    end

    // Unmapped address flag, shown only in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_reg <= 1'b0;
        end else if (setup_phase) begin
            pslverr_reg <= ~hit_any;
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = pslverr_reg & access_phase;

    // Writes load latch; other resets leave it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_c_data_reg <= PORT_LATCH_RST;
        end else if (wr_pc_data) begin
            port_c_data_reg <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_d_data_reg <= PORT_LATCH_RST;
        end else if (wr_pd_data) begin
            port_d_data_reg <= wbyte;
        end
    end

    // Port C inputs after any reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_c_direction_reg <= PORT_DIR_RST;
        end else if (!other_reset_n) begin
            port_c_direction_reg <= PORT_DIR_RST;
        end else if (wr_pc_dir) begin
            port_c_direction_reg <= wbyte;
        end
    end

    // Port D inputs after any reset; one bit per pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_d_direction_reg <= PORT_DIR_RST;
        end else if (!other_reset_n) begin
            port_d_direction_reg <= PORT_DIR_RST;
        end else if (wr_pd_dir) begin
            port_d_direction_reg <= wbyte;
        end
    end

    // Mode bit, writable with port E directions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psp_mode_reg <= PSP_MODE_RST;
            port_e_dir_reg <= PORT_E_DIR_RST;
        end else if (!other_reset_n) begin
            psp_mode_reg <= PSP_MODE_RST;
            port_e_dir_reg <= PORT_E_DIR_RST;
        end else if (wr_pe_dir) begin
            psp_mode_reg <= wbyte[PE_MODE_BIT];
            port_e_dir_reg <= wbyte[PE_DIR_MSB:PE_DIR_LSB];
        end
    end

    // One-cycle clear request toward the slave logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_clear_reg <= 1'b0;
        end else if (!other_reset_n) begin
            ovf_clear_reg <= 1'b0;
        end else begin
            ovf_clear_reg <= ovf_clear_next;
        end
    end

    assign slave_overflow_clear = ovf_clear_reg;
    assign parallel_slave_mode_select = psp_mode_reg;
    assign port_e_direction = port_e_dir_reg;

    // Pins that may be handed to peripherals on this variant
    // Serial pins 3..5; unit one on pin 2; timer1 on pin 0
    // Pin 1 carries the oscillator and, if present, unit two
    // Pins 6 and 7 only with a USART
    localparam logic [PORT_W-1:0] SEL_MASK =
        HAS_USART ? (PC_BASE_SEL_MASK | PC_USART_SEL_MASK) : PC_BASE_SEL_MASK;

    wire [PORT_W-1:0] sel_eff = periph_sel & SEL_MASK;

    // Next pin drive values, one slice per pin
    wire [PORT_W-1:0] pc_out_next;
    wire [PORT_W-1:0] pc_oe_next;
    wire [PORT_W-1:0] pd_out_next;
    wire [PORT_W-1:0] pd_oe_next;

    for (genvar g = 0; g < PORT_W; g++) begin : g_pin
        assign pc_out_next[g] = sel_eff[g] ? periph_out[g] : port_c_data_reg[g];
        // Otherwise a zero direction bit drives the pin
        assign pc_oe_next[g] = sel_eff[g] ? periph_oe[g] : ~port_c_direction_reg[g];

        // Slave bit n on pin n; directions ignored then
        assign pd_out_next[g] = psp_mode_reg ? slave_data_out[g] : port_d_data_reg[g];
        assign pd_oe_next[g] = psp_mode_reg ? slave_data_drive : ~port_d_direction_reg[g];
    end

    // Registered drivers avoid glitches when selects change; costs one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_out_reg <= BYTE_ZERO;
            pc_oe_reg <= BYTE_ZERO;
        end else begin
            pc_out_reg <= pc_out_next;
            pc_oe_reg <= pc_oe_next;
        end
    end

    // Port D drivers, same latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_out_reg <= BYTE_ZERO;
            pd_oe_reg <= BYTE_ZERO;
        end else begin
            pd_out_reg <= pd_out_next;
            pd_oe_reg <= pd_oe_next;
        end
    end

    assign port_c_pin_out = pc_out_reg;
    assign port_c_pin_oe = pc_oe_reg;
    assign port_d_pin_out = pd_out_reg;
    assign port_d_pin_oe = pd_oe_reg;

    // Peripheral inputs (capture, data in, receive, timer clock) read these
    // Oscillator pins need analog pads; only the digital view is here
    assign port_c_level = pc_sync;
    assign port_d_level = pd_sync;

    // Unit two shares pin 1 with the oscillator; a parameter keeps it visible
    wire unused_ok = HAS_CAPTURE_COMPARE_PWM_UNIT_TWO | (&pstrb[3:1]) | (|pwdata[DATA_W-1:PORT_W]);
endmodule
`default_nettype wire

// File: verif/gpcd_checker.sv
// Port-level checks for the port C / port D block
`default_nettype none
module gpcd_checker
    import gpcd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic other_reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpcd_pkg::ADDR_W-1:0] paddr,
    input wire logic [gpcd_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [gpcd_pkg::PORT_W-1:0] port_c_pin_out,
    input wire logic [gpcd_pkg::PORT_W-1:0] port_c_pin_oe,
    input wire logic [gpcd_pkg::PORT_W-1:0] port_d_pin_out,
    input wire logic [gpcd_pkg::PORT_W-1:0] port_d_pin_oe,
    input wire logic [gpcd_pkg::PORT_W-1:0] periph_sel,
    input wire logic [gpcd_pkg::PORT_W-1:0] periph_out,
    input wire logic [gpcd_pkg::PORT_W-1:0] periph_oe,
    input wire logic [gpcd_pkg::PORT_W-1:0] slave_data_out,
    input wire logic slave_data_drive,
    input wire logic slave_input_full,
    input wire logic slave_output_full,
    input wire logic slave_input_overflow,
    input wire logic parallel_slave_mode_select,
    input wire logic [2:0] port_e_direction
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pc_out_sel: assert property ($past(presetn) |->
        ((port_c_pin_out ^ $past(periph_out)) & $past(periph_sel)) == 8'h00)
        else $error("selected pin not fed by peripheral");
    a_pc_oe_sel: assert property ($past(presetn) |->
        ((port_c_pin_oe ^ $past(periph_oe)) & $past(periph_sel)) == 8'h00)
        else $error("selected pin enable not from peripheral");
    a_pd_slave_map: assert property ($past(presetn) && $past(parallel_slave_mode_select) |->
        port_d_pin_out == $past(slave_data_out) && port_d_pin_oe == {8{$past(slave_data_drive)}})
        else $error("slave byte not on port D");
    a_dir_reset: assert property (!other_reset_n ##1 other_reset_n |=>
        (port_c_pin_oe & ~$past(periph_sel)) == 8'h00 && port_d_pin_oe == 8'h00)
        else $error("pins not inputs after reset");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    a_ready_access: assert property (psel && penable |-> pready)
        else $error("access phase stalled");
    a_rdata_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_pe_read: assert property (psel && penable && !pwrite && paddr == ADDR_PORT_E_DIR |->
        prdata[7:0] == {$past(slave_input_full), $past(slave_output_full),
        $past(slave_input_overflow), $past(parallel_slave_mode_select), 1'b0,
        $past(port_e_direction)})
        else $error("port E register read wrong");
endmodule
bind gpcd_ports gpcd_checker i_gpcd_checker (.pclk, .presetn, .other_reset_n, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .port_c_pin_out, .port_c_pin_oe,
    .port_d_pin_out, .port_d_pin_oe, .periph_sel, .periph_out, .periph_oe, .slave_data_out,
    .slave_data_drive, .slave_input_full, .slave_output_full, .slave_input_overflow,
    .parallel_slave_mode_select, .port_e_direction);
`default_nettype wire

// File: verif/gpcd_pin_model.sv
// Pad and outside-circuit model for ports C and D
`default_nettype none
module gpcd_pin_model (
    input wire logic pclk,
    input wire logic [7:0] port_c_pin_out,
    input wire logic [7:0] port_c_pin_oe,
    input wire logic [7:0] port_d_pin_out,
    input wire logic [7:0] port_d_pin_oe,
    input wire logic [7:0] c_ext,
    input wire logic [7:0] c_ext_oe,
    input wire logic [7:0] d_ext,
    input wire logic [7:0] d_ext_oe,
    output logic [7:0] port_c_pin_in,
    output logic [7:0] port_d_pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] flt = 8'h5a;
    // No pull resistor: a released pad must not hold its last level
    always_ff @(posedge pclk) flt <= ~flt;
    // device drives only its output pins
    assign port_c_pin_in = (port_c_pin_oe & port_c_pin_out) | (~port_c_pin_oe & c_ext_oe & c_ext)
        | (~port_c_pin_oe & ~c_ext_oe & flt);
    assign port_d_pin_in = (port_d_pin_oe & port_d_pin_out) | (~port_d_pin_oe & d_ext_oe & d_ext)
        | (~port_d_pin_oe & ~d_ext_oe & flt);
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the port C / port D block
`default_nettype none
module testbench;
    import gpcd_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 1'b0, presetn = 1'b0, other_reset_n = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, slave_overflow_clear, parallel_slave_mode_select;
    logic slave_data_drive = 1'b0, slave_input_full = 1'b0, slave_output_full = 1'b0;
    logic slave_input_overflow = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hf;
    logic [2:0] port_e_direction;
    logic [7:0] port_c_pin_in, port_c_pin_out, port_c_pin_oe, port_c_level, port_d_level;
    logic [7:0] port_d_pin_in, port_d_pin_out, port_d_pin_oe, slave_data_out = 8'h00;
    logic [7:0] periph_sel = 8'h00, periph_out = 8'h00, periph_oe = 8'h00;
    logic [7:0] c_ext = 8'h00, c_ext_oe = 8'h00, d_ext = 8'h00, d_ext_oe = 8'h00;
    int bad_count = 0, num_checks = 0;
    always #5 pclk = ~pclk;
    gpcd_ports i_gpcd_ports (.pclk, .presetn, .other_reset_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .port_c_pin_in, .port_c_pin_out,
        .port_c_pin_oe, .port_d_pin_in, .port_d_pin_out, .port_d_pin_oe, .periph_sel, .periph_out,
        .periph_oe, .port_c_level, .port_d_level, .slave_data_out, .slave_data_drive,
        .slave_input_full, .slave_output_full, .slave_input_overflow, .slave_overflow_clear,
        .parallel_slave_mode_select, .port_e_direction);
    gpcd_pin_model i_gpcd_pin_model (.pclk, .port_c_pin_out, .port_c_pin_oe, .port_d_pin_out,
        .port_d_pin_oe, .c_ext, .c_ext_oe, .d_ext, .d_ext_oe, .port_c_pin_in, .port_d_pin_in);
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            $display("mismatch at %0t: no bus answer", $time);
            test_done();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r[7:0], exp);
    endtask
    task automatic wt();
        @(posedge pclk);
        #1;
    endtask
    task automatic drv(input logic [7:0] s, input logic [7:0] o, input logic [7:0] e);
        @(posedge pclk);
        periph_sel <= s;
        periph_out <= o;
        periph_oe <= e;
        wt();
    endtask
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rd(ADDR_PORT_C_DIR, 8'hff);
        rd(ADDR_PORT_D_DIR, 8'hff);
        rd(ADDR_PORT_E_DIR, 8'h07);
        chk(port_c_pin_oe | port_d_pin_oe, 8'h00);
        chk({parallel_slave_mode_select, slave_overflow_clear, 3'h0, port_e_direction}, 8'h07);
        apb(1'b0, 12'h000, 32'h0, r, e);
        chk({7'h00, e}, 8'h01);
    endtask
    task automatic t_port_c_data();
        wr(ADDR_PORT_C_DATA, 32'h0);
        wr(ADDR_PORT_C_DIR, 32'hcf);
        wr(ADDR_PORT_C_DATA, 32'h30);
        c_ext <= 8'h0a;
        c_ext_oe <= 8'hcf;
        repeat (3) wt();
        chk(port_c_pin_oe, 8'h30);
        chk(port_c_level, 8'h3a);
        rd(ADDR_PORT_C_DATA, 8'h3a);
    endtask
    task automatic t_periph();
        logic [7:0] s;
        // every pin handed over in turn
        for (int i = 0; i < 8; i++) begin
            s = 8'h01 << i;
            drv(s, 8'hcf, s);
            chk(port_c_pin_out, (8'h30 & ~s) | (8'hcf & s));
            chk(port_c_pin_oe, 8'h30 | s);
            drv(s, 8'hcf, 8'h00);
            chk(port_c_pin_oe, 8'h30 & ~s);
        end
        drv(8'h00, 8'hcf, 8'hff);
        chk(port_c_pin_oe, 8'h30);
        chk(port_c_pin_out, 8'h30);
    endtask
    task automatic t_port_d_data();
        wr(ADDR_PORT_D_DATA, 32'h5a);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_PORT_D_DIR, {24'h0, ~(8'h01 << i)});
            wt();
            chk(port_d_pin_oe, 8'h01 << i);
        end
        chk(port_d_pin_out, 8'h5a);
        d_ext <= 8'h33;
        d_ext_oe <= 8'h7f;
        repeat (3) wt();
        chk(port_d_level, 8'h33);
        rd(ADDR_PORT_D_DATA, 8'h33);
        d_ext_oe <= 8'h00;
    endtask
    task automatic t_slave();
        slave_data_out <= 8'ha5;
        slave_data_drive <= 1'b1;
        slave_input_full <= 1'b1;
        slave_input_overflow <= 1'b1;
        wr(ADDR_PORT_E_DIR, 32'h1d);
        #1;
        chk({7'h00, slave_overflow_clear}, 8'h01);
        wt();
        chk({7'h00, slave_overflow_clear}, 8'h00);
        chk({7'h00, parallel_slave_mode_select}, 8'h01);
        chk({5'h00, port_e_direction}, 8'h05);
        chk(port_d_pin_out, 8'ha5);
        chk(port_d_pin_oe, 8'hff);
        rd(ADDR_PORT_E_DIR, 8'hb5);
        wr(ADDR_PORT_E_DIR, 32'h07);
        wt();
        chk({7'h00, parallel_slave_mode_select}, 8'h00);
        chk(port_d_pin_out, 8'h5a);
        chk(port_d_pin_oe, 8'h80);
    endtask
    task automatic t_other();
        wr(ADDR_PORT_C_DIR, 32'h0);
        wr(ADDR_PORT_C_DATA, 32'h55);
        pstrb <= 4'he;
        wr(ADDR_PORT_C_DATA, 32'haa);
        pstrb <= 4'hf;
        wr(ADDR_PORT_E_DIR, 32'h12);
        other_reset_n <= 1'b0;
        @(posedge pclk);
        other_reset_n <= 1'b1;
        rd(ADDR_PORT_C_DIR, 8'hff);
        rd(ADDR_PORT_D_DIR, 8'hff);
        rd(ADDR_PORT_E_DIR, 8'ha7);
        chk({parallel_slave_mode_select, 4'h0, port_e_direction}, 8'h07);
        wt();
        chk(port_c_pin_oe, 8'h00);
        chk(port_c_pin_out, 8'h55);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_port_c_data();
        t_periph();
        t_port_d_data();
        t_slave();
        t_other();
        test_done();
    end
endmodule
`default_nettype wire
